/* File: wkelm_pkg.sv */
package wkelm_pkg;

    // Controller external data space addresses
    localparam logic [15:0] ADDR_SOURCE_ONE   = 16'h7F2A;
    localparam logic [15:0] ADDR_SOURCE_TWO   = 16'h7F2B;
    localparam logic [15:0] ADDR_MASK_ONE     = 16'h7F2C;
    localparam logic [15:0] ADDR_MASK_TWO     = 16'h7F2D;
    localparam logic [15:0] ADDR_SOURCE_THREE = 16'h7F35;
    localparam logic [15:0] ADDR_MASK_THREE   = 16'h7F36;

    // Values after reset
    localparam logic [7:0] RST_SOURCE     = 8'h00;
    localparam logic [7:0] RST_MASK_ONE   = 8'h00;
    localparam logic [7:0] RST_MASK_TWO   = 8'h00;
    localparam logic [7:0] RST_MASK_THREE = 8'hFF;
    localparam logic [7:0] RST_RDATA      = 8'h00;

    // Live bits of the third source and mask registers
    localparam logic [7:0] THIRD_LIVE_BITS = 8'h07;

    localparam int EVENT_COUNT = 19;

    // Event index: source one is 0..7, two is 8..15, three is 16..18
    localparam int EV_CLOCK_ALARM   = 0;
    localparam int EV_TOGGLE_1      = 1;
    localparam int EV_FALLING_4     = 2;
    localparam int EV_FALLING_3     = 3;
    localparam int EV_SERIAL_BUS    = 4;
    localparam int EV_FALLING_1     = 5;
    localparam int EV_FALLING_2     = 6;
    localparam int EV_FALLING_5     = 7;
    localparam int EV_GENERAL_WAKE  = 8;
    localparam int EV_FALLING_6     = 9;
    localparam int EV_HIBERNATION   = 10;
    localparam int EV_TOGGLE_3      = 11;
    localparam int EV_TOGGLE_2      = 12;
    localparam int EV_TOGGLE_4      = 13;
    localparam int EV_PORT1_RING    = 14;
    localparam int EV_PORT2_RING    = 15;
    localparam int EV_ANY_KEY       = 16;
    localparam int EV_INFRARED_A    = 17;
    localparam int EV_INFRARED_B    = 18;

    // Which edges of each raw input raise its event
    localparam logic [18:0] RISE_EDGES = 19'h13C03;
    localparam logic [18:0] FALL_EDGES = 19'h6FBFE;

    typedef enum logic [1:0] {
        OSC_IDLE,
        OSC_STARTING,
        OSC_RESUMED
    } wkelm_osc_t;

endpackage

/* File: wkelm_edge.sv */
`timescale 1ns/1ps
module wkelm_edge
    import wkelm_pkg::*;
#(
    parameter int          WIDTH = 19,
    parameter logic [18:0] RISE  = RISE_EDGES,
    parameter logic [18:0] FALL  = FALL_EDGES
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Levels in, one-cycle edge pulses out
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] edgePulse
);

    logic [WIDTH-1:0] prevLevel_r;
    logic             primed_r;

    // First cycle after reset only samples, so no false edge appears
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            primed_r <= 1'b0;
        end else begin
            primed_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prevLevel_r <= '0;
        end else begin
            prevLevel_r <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign edgePulse[i] = primed_r
                & ((RISE[i] & level[i] & ~prevLevel_r[i])
                |  (FALL[i] & ~level[i] & prevLevel_r[i]));
        end
    endgenerate

endmodule

/* File: wkelm_wakeup.sv */
`timescale 1ns/1ps
module wkelm_wakeup
    import wkelm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Controller external data space port
    input  wire logic [15:0] cpuAddr,
    input  wire logic        cpuRead,
    input  wire logic        cpuWrite,
    input  wire logic [7:0]  cpuWdata,
    output logic      [7:0]  cpuRdata_r,
    // External wake pins
    input  wire logic        fallingWake1,
    input  wire logic        fallingWake2,
    input  wire logic        fallingWake3,
    input  wire logic        fallingWake4,
    input  wire logic        fallingWake5,
    input  wire logic        fallingWake6,
    input  wire logic        toggleWake1,
    input  wire logic        toggleWake2,
    input  wire logic        toggleWake3,
    input  wire logic        toggleWake4,
    input  wire logic        generalWakeN,
    input  wire logic        serialPort1RingN,
    input  wire logic        serialPort2RingN,
    input  wire logic [7:0]  scanInLines,
    input  wire logic        sharedIo8,
    input  wire logic        irReceivePin,
    // Internal event sources
    input  wire logic        serialBusData,
    input  wire logic        timeOfDayAlarm,
    input  wire logic        hibernationZero,
    // Sleep control
    input  wire logic        sleepActive,
    input  wire logic        oscStable,
    output logic             wakeRequest_r,
    output logic             ringOscStart_r,
    output logic             resumeCore_r
);

    logic [18:0] rawLevel;
    logic [18:0] eventPulse;
    logic [7:0]  sourceOne_r;
    logic [7:0]  sourceTwo_r;
    logic [2:0]  sourceThree_r;
    logic [7:0]  maskOne_r;
    logic [7:0]  maskTwo_r;
    logic [7:0]  maskThree_r;
    logic        anyKey;
    logic        wakeRequest_nxt;
    wkelm_osc_t  oscState_r;

    function automatic logic hit(input logic [15:0] addr,
                                 input logic [15:0] target);
        hit = (addr == target);
    endfunction

    assign anyKey = ~(&scanInLines);

    // Raw levels placed at their event index
    always_comb begin
        rawLevel                  = '0;
        rawLevel[EV_CLOCK_ALARM]  = timeOfDayAlarm;
        rawLevel[EV_TOGGLE_1]     = toggleWake1;
        rawLevel[EV_FALLING_4]    = fallingWake4;
        rawLevel[EV_FALLING_3]    = fallingWake3;
        rawLevel[EV_SERIAL_BUS]   = serialBusData;
        rawLevel[EV_FALLING_1]    = fallingWake1;
        rawLevel[EV_FALLING_2]    = fallingWake2;
        rawLevel[EV_FALLING_5]    = fallingWake5;
        rawLevel[EV_GENERAL_WAKE] = generalWakeN;
        rawLevel[EV_FALLING_6]    = fallingWake6;
        rawLevel[EV_HIBERNATION]  = hibernationZero;
        rawLevel[EV_TOGGLE_3]     = toggleWake3;
        rawLevel[EV_TOGGLE_2]     = toggleWake2;
        rawLevel[EV_TOGGLE_4]     = toggleWake4;
        rawLevel[EV_PORT1_RING]   = serialPort1RingN;
        rawLevel[EV_PORT2_RING]   = serialPort2RingN;
        rawLevel[EV_ANY_KEY]      = anyKey;
        rawLevel[EV_INFRARED_A]   = sharedIo8;
        rawLevel[EV_INFRARED_B]   = irReceivePin;
    end

    // Edge sensing only, so a held alarm match cannot re-set after a read
    wkelm_edge #(
        .WIDTH (EVENT_COUNT),
        .RISE  (RISE_EDGES),
        .FALL  (FALL_EDGES)
    ) u_edge (
        .clock     (clock),
        .rst_n     (rst_n),
        .level     (rawLevel),
        .edgePulse (eventPulse)
    );

    // Sources: a read clears, a same-cycle event wins over the clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sourceOne_r <= RST_SOURCE;
        end else if (cpuRead && hit(cpuAddr, ADDR_SOURCE_ONE)) begin
            sourceOne_r <= eventPulse[7:0];
        end else begin
            sourceOne_r <= sourceOne_r | eventPulse[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sourceTwo_r <= RST_SOURCE;
        end else if (cpuRead && hit(cpuAddr, ADDR_SOURCE_TWO)) begin
            sourceTwo_r <= eventPulse[15:8];
        end else begin
            sourceTwo_r <= sourceTwo_r | eventPulse[15:8];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sourceThree_r <= RST_SOURCE[2:0];
        end else if (cpuRead && hit(cpuAddr, ADDR_SOURCE_THREE)) begin
            sourceThree_r <= eventPulse[18:16];
        end else begin
            sourceThree_r <= sourceThree_r | eventPulse[18:16];
        end
    end

    // Masks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            maskOne_r <= RST_MASK_ONE;
        end else if (cpuWrite && hit(cpuAddr, ADDR_MASK_ONE)) begin
            maskOne_r <= cpuWdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            maskTwo_r <= RST_MASK_TWO;
        end else if (cpuWrite && hit(cpuAddr, ADDR_MASK_TWO)) begin
            maskTwo_r <= cpuWdata;
        end
    end

    // Reserved bits are stored and read back but gate nothing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            maskThree_r <= RST_MASK_THREE;
        end else if (cpuWrite && hit(cpuAddr, ADDR_MASK_THREE)) begin
            maskThree_r <= cpuWdata;
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpuRdata_r <= RST_RDATA;
        end else if (cpuRead) begin
            case (cpuAddr)
                ADDR_SOURCE_ONE:   cpuRdata_r <= sourceOne_r;
                ADDR_SOURCE_TWO:   cpuRdata_r <= sourceTwo_r;
                ADDR_SOURCE_THREE: cpuRdata_r <= {5'h00, sourceThree_r};
                ADDR_MASK_ONE:     cpuRdata_r <= maskOne_r;
                ADDR_MASK_TWO:     cpuRdata_r <= maskTwo_r;
                ADDR_MASK_THREE:   cpuRdata_r <= maskThree_r;
                default:           cpuRdata_r <= RST_RDATA;
            endcase
        end
    end

    // Single request from latched, unmasked events
    assign wakeRequest_nxt = (|(sourceOne_r & ~maskOne_r))
        | (|(sourceTwo_r & ~maskTwo_r))
        | (|(sourceThree_r & ~maskThree_r[2:0]));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wakeRequest_r <= 1'b0;
        end else begin
            wakeRequest_r <= wakeRequest_nxt;
        end
    end

    // Oscillator start and resume sequence
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oscState_r     <= OSC_IDLE;
            ringOscStart_r <= 1'b0;
            resumeCore_r   <= 1'b0;
        end else begin
            resumeCore_r <= 1'b0;
            case (oscState_r)
                OSC_IDLE: begin
                    if (sleepActive && wakeRequest_r) begin
                        oscState_r     <= OSC_STARTING;
                        ringOscStart_r <= 1'b1;
                    end
                end
                OSC_STARTING: begin
                    if (oscStable) begin
                        oscState_r   <= OSC_RESUMED;
                        resumeCore_r <= 1'b1;
                    end
                end
                OSC_RESUMED: begin
                    // Core owns the oscillator once it leaves sleep
                    if (!sleepActive) begin
                        oscState_r     <= OSC_IDLE;
                        ringOscStart_r <= 1'b0;
                    end
                end
                default: begin
                    oscState_r     <= OSC_IDLE;
                    ringOscStart_r <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* File: wkelm_wakeup_monitor.sv */
`timescale 1ns/1ps
module wkelm_wakeup_monitor
    import wkelm_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [15:0] cpuAddr,
    input wire logic        cpuRead,
    input wire logic        cpuWrite,
    input wire logic [7:0]  cpuWdata,
    input wire logic [7:0]  cpuRdata_r,
    // Sleep handshake
    input wire logic        sleepActive,
    input wire logic        oscStable,
    input wire logic        wakeRequest_r,
    input wire logic        ringOscStart_r,
    input wire logic        resumeCore_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wrRd(logic [15:0] a);
        cpuWrite && cpuAddr == a ##1 !cpuWrite
            ##1 cpuRead && !cpuWrite && cpuAddr == a;
    endsequence
    sequence s_oscUp;
        ringOscStart_r && $rose(oscStable);
    endsequence
    property p_maskOne;
        s_wrRd(ADDR_MASK_ONE) |=> cpuRdata_r == $past(cpuWdata, 3);
    endproperty
    property p_maskTwo;
        s_wrRd(ADDR_MASK_TWO) |=> cpuRdata_r == $past(cpuWdata, 3);
    endproperty
    property p_maskThree;
        s_wrRd(ADDR_MASK_THREE) |=> cpuRdata_r == $past(cpuWdata, 3);
    endproperty
    property p_srcThree;
        cpuRead && cpuAddr == ADDR_SOURCE_THREE |=> cpuRdata_r[7:3] == 5'h00;
    endproperty
    property p_oscStart;
        sleepActive && wakeRequest_r |=> ringOscStart_r;
    endproperty
    property p_resume;
        s_oscUp |=> resumeCore_r;
    endproperty
    property p_pulse;
        resumeCore_r |=> !resumeCore_r;
    endproperty
    property p_oscHold;
        ringOscStart_r && sleepActive |=> ringOscStart_r;
    endproperty
    property p_oscDrop;
        !sleepActive |=> !ringOscStart_r;
    endproperty
    // Request only falls after an access cleared bits or changed a mask
    property p_wakeFall;
        $fell(wakeRequest_r) |-> $past(cpuRead | cpuWrite, 1)
            || $past(cpuRead | cpuWrite, 2) || $past(cpuRead | cpuWrite, 3);
    endproperty
    a_maskOne: assert property (p_maskOne)
        else $error("mask one read back differs");
    a_maskTwo: assert property (p_maskTwo)
        else $error("mask two read back differs");
    a_maskThree: assert property (p_maskThree)
        else $error("mask three read back differs");
    a_srcThree: assert property (p_srcThree)
        else $error("source three reserved bits not zero");
    a_oscStart: assert property (p_oscStart)
        else $error("oscillator not started on wake");
    a_resume: assert property (p_resume)
        else $error("no resume after oscillator stable");
    a_pulse: assert property (p_pulse)
        else $error("resume longer than one cycle");
    a_oscHold: assert property (p_oscHold)
        else $error("oscillator request dropped in sleep");
    a_oscDrop: assert property (p_oscDrop)
        else $error("oscillator request held when awake");
    a_wakeFall: assert property (p_wakeFall)
        else $error("wake request fell without access");
endmodule

/* File: wkelm_cpu_model.sv */
`timescale 1ns/1ps
module wkelm_cpu_model #(
    parameter int OSC_DELAY = 4
) (
    // Clock and register port
    input  wire logic        clock,
    output logic      [15:0] cpuAddr,
    output logic             cpuRead,
    output logic             cpuWrite,
    output logic      [7:0]  cpuWdata,
    input  wire logic [7:0]  cpuRdata_r,
    // Ring oscillator
    input  wire logic        ringOscStart_r,
    output logic             oscStable
);
    int oscCount = 0;
    initial begin
        cpuAddr = 16'h0000;
        cpuRead = 1'b0;
        cpuWrite = 1'b0;
        cpuWdata = 8'h00;
    end
    // Settling time restarts whenever the request goes away
    always @(posedge clock) begin
        if (!ringOscStart_r) begin
            oscCount <= 0;
        end else if (oscCount < OSC_DELAY) begin
            oscCount <= oscCount + 1;
        end
    end
    assign oscStable = (oscCount == OSC_DELAY);
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        cpuAddr = a;
        cpuWdata = d;
        cpuWrite = 1'b1;
        @(posedge clock);
        #1;
        cpuWrite = 1'b0;
        // Released bus shows junk, never the last value
        cpuAddr = ~a;
        cpuWdata = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        cpuAddr = a;
        cpuRead = 1'b1;
        @(posedge clock);
        #1;
        cpuRead = 1'b0;
        cpuAddr = ~a;
        d = cpuRdata_r;
    endtask
endmodule

/* File: wkelm_wakeup_tb.sv */
`timescale 1ns/1ps
module wkelm_wakeup_tb;
    import wkelm_pkg::*;
    // Alarm and hibernation pins idle low, all others idle high
    localparam logic [18:0] IDLE    = 19'h7FBFE;
    localparam logic [18:0] TOGGLES = 19'h03802;
    logic        clock;
    logic        rst_n;
    logic [18:0] pins;
    logic        sleepActive;
    logic [15:0] cpuAddr;
    logic        cpuRead;
    logic        cpuWrite;
    logic [7:0]  cpuWdata;
    logic [7:0]  cpuRdata_r;
    logic        oscStable;
    logic        wakeRequest_r;
    logic        ringOscStart_r;
    logic        resumeCore_r;
    logic [7:0]  v;
    logic [15:0] regAddr [3];
    int          n_fail = 0;
    int          cmp_count = 0;
    int          k;
    wkelm_cpu_model cpu (.clock, .cpuAddr, .cpuRead, .cpuWrite, .cpuWdata,
        .cpuRdata_r, .ringOscStart_r, .oscStable);
    wkelm_wakeup DUT (.clock, .rst_n, .cpuAddr, .cpuRead, .cpuWrite,
        .cpuWdata, .cpuRdata_r, .fallingWake1(pins[5]),
        .fallingWake2(pins[6]), .fallingWake3(pins[3]),
        .fallingWake4(pins[2]), .fallingWake5(pins[7]),
        .fallingWake6(pins[9]), .toggleWake1(pins[1]),
        .toggleWake2(pins[12]), .toggleWake3(pins[11]),
        .toggleWake4(pins[13]), .generalWakeN(pins[8]),
        .serialPort1RingN(pins[14]), .serialPort2RingN(pins[15]),
        .scanInLines({4'hF, pins[16], 3'h7}), .sharedIo8(pins[17]),
        .irReceivePin(pins[18]), .serialBusData(pins[4]),
        .timeOfDayAlarm(pins[0]), .hibernationZero(pins[10]),
        .sleepActive, .oscStable, .wakeRequest_r, .ringOscStart_r,
        .resumeCore_r);
    task automatic chk(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] e, string n);
        cpu.rd(a, v);
        chk(n, v, e);
    endtask
    task automatic wrc(input logic [15:0] a, input logic [7:0] d, string n);
        cpu.wr(a, d);
        rc(a, d, n);
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        pins = IDLE;
        sleepActive = 1'b0;
        regAddr = '{ADDR_SOURCE_ONE, ADDR_SOURCE_TWO, ADDR_SOURCE_THREE};
        tick(10);
        rst_n = 1'b1;
        tick(2);
        rc(ADDR_SOURCE_ONE, 8'h00, "src1");
        rc(ADDR_SOURCE_TWO, 8'h00, "src2");
        rc(ADDR_SOURCE_THREE, 8'h00, "src3");
        rc(ADDR_MASK_ONE, 8'h00, "mask1");
        rc(ADDR_MASK_TWO, 8'h00, "mask2");
        rc(ADDR_MASK_THREE, 8'hFF, "mask3");
        for (int i = 0; i < 19; i++) begin
            tick(1);
            pins[i] = ~pins[i];
            tick(3);
            chk("wake", {7'h00, wakeRequest_r}, {7'h00, i < 16});
            rc(regAddr[i/8], 8'h01 << (i % 8), "event");
            rc(regAddr[i/8], 8'h00, "cleared");
            pins[i] = ~pins[i];
            tick(3);
            rc(regAddr[i/8], TOGGLES[i] ? 8'h01 << (i % 8) : 8'h00,
               "back");
        end
        fork
            cpu.rd(ADDR_SOURCE_ONE, v);
            begin
                tick(1);
                pins[5] = 1'b0;
            end
        join
        chk("race", v, 8'h00);
        rc(ADDR_SOURCE_ONE, 8'h20, "kept");
        cpu.wr(ADDR_SOURCE_TWO, 8'hFF);
        rc(ADDR_SOURCE_TWO, 8'h00, "rdonly");
        cpu.wr(16'h7F2E, 8'hFF);
        rc(16'h7F2E, 8'h00, "unmapped");
        wrc(ADDR_MASK_ONE, 8'hFE, "mask1");
        wrc(ADDR_MASK_TWO, 8'hFF, "mask2");
        wrc(ADDR_MASK_THREE, 8'hF8, "mask3");
        pins[7] = 1'b0;
        tick(4);
        chk("masked", {7'h00, wakeRequest_r}, 8'h00);
        rc(ADDR_SOURCE_ONE, 8'h80, "latched");
        pins[16] = 1'b0;
        tick(4);
        chk("anykey", {7'h00, wakeRequest_r}, 8'h01);
        sleepActive = 1'b1;
        k = 0;
        while (resumeCore_r !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        chk("resume", {7'h00, resumeCore_r}, 8'h01);
        sleepActive = 1'b0;
        tick(2);
        chk("oscoff", {7'h00, ringOscStart_r}, 8'h00);
        final_report();
    end
endmodule
bind wkelm_wakeup wkelm_wakeup_monitor u_mon (.clock, .rst_n, .cpuAddr,
    .cpuRead, .cpuWrite, .cpuWdata, .cpuRdata_r, .sleepActive, .oscStable,
    .wakeRequest_r, .ringOscStart_r, .resumeCore_r);
